//--- mbcd_ctrl.sv
// Control unit, digit chain and comparator of the modular decade counter
`timescale 1ns/100ps
module mbcd_ctrl #(
   parameter int unsigned NUM_DIGITS = 4,
   parameter int unsigned SLOW_WIDTH = mbcd_pkg::SLOW_WIDTH_CYC,
   parameter int unsigned FAST_WIDTH = mbcd_pkg::FAST_WIDTH_CYC,
   parameter int unsigned ONE_SHOT = mbcd_pkg::ONE_SHOT_CYC
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Clear and count terminals
   input wire mbcd_pkg::mbcd_inputs_t inputs,
   // Configuration straps
   input wire mbcd_pkg::mbcd_straps_t straps,
   // Preset digits, lowest digit in the low nibble
   input wire logic [NUM_DIGITS*mbcd_pkg::DIGIT_W-1:0] preset_bcd,
   // Thumbwheel coincidence lines for the comparator unit
   input wire logic [mbcd_pkg::THUMB_LINES-1:0] thumbwheel_coincidence_in,
   // Digit outputs, one bit per digit for each weight
   output logic [NUM_DIGITS-1:0] bcd_out_weight1,
   output logic [NUM_DIGITS-1:0] bcd_out_weight2,
   output logic [NUM_DIGITS-1:0] bcd_out_weight4,
   output logic [NUM_DIGITS-1:0] bcd_out_weight8,
   // Pulses and control outputs
   output logic count_pulse_out,
   output logic carry_pulse_out,
   output logic control_out,
   output logic comparator_out
);
   import mbcd_pkg::*;

   localparam int unsigned NIN = $bits(mbcd_inputs_t) + $bits(mbcd_straps_t);

   // ==========================================
   // State
   typedef struct packed {
      logic [NIN-1:0] sync1;
      logic [NIN-1:0] sync2;
      logic [1:0] filt;
      logic [1:0][TIMER_W-1:0] filt_cnt;
      logic [NUM_DIGITS-1:0][DIGIT_W-1:0] digit;
      logic match_prev;
      logic [TIMER_W-1:0] shot_cnt;
      logic ctrl;
      logic pulse;
      logic carry;
      logic cmp;
   } mbcd_state_t;

   mbcd_state_t state;
   mbcd_state_t next_state;

   // Reset image: synchronisers start at idle terminal levels, so no false clear or count edge
   // follows reset; coincidence counts as already seen, so reset alone raises no control output
   localparam mbcd_state_t STATE_RST = '{
      sync1: {INPUTS_IDLE, STRAPS_IDLE},
      sync2: {INPUTS_IDLE, STRAPS_IDLE},
      filt: 2'b00,
      filt_cnt: '0,
      digit: {NUM_DIGITS{DIGIT_RST}},
      match_prev: 1'b1,
      shot_cnt: '0,
      ctrl: 1'b0,
      pulse: 1'b0,
      carry: 1'b0,
      cmp: 1'b0
   };

   // Elaboration check of parameters; every timer is TIMER_W bits wide
   if (NUM_DIGITS < 1 || NUM_DIGITS > THUMB_LINES || SLOW_WIDTH < 1 || FAST_WIDTH < 1 || ONE_SHOT < 1 ||
       SLOW_WIDTH >= (1 << TIMER_W) || FAST_WIDTH >= (1 << TIMER_W) ||
       ONE_SHOT >= (1 << TIMER_W)) begin : g_bad_params
      $error("mbcd_ctrl: unsupported parameter values");
   end

   // ==========================================
   // Decoded views of the synchronised inputs
   mbcd_inputs_t in_s;
   mbcd_straps_t strap_s;
   mbcd_in_mode_t in_mode;
   logic clear_now;
   logic [1:0] count_lvl;
   logic [TIMER_W-1:0] min_width;
   logic [NUM_DIGITS-1:0][DIGIT_W-1:0] target;
   logic match_now;

   assign {in_s, strap_s} = state.sync2;
   // Straps read 0 when tied to common and 1 when open
   assign in_mode = mbcd_in_mode_t'({strap_s.input_mode_strap_first, strap_s.input_mode_strap_second});
   // Shorted contact or driven voltage terminal both apply the clear
   assign clear_now = !in_s.clear_contact_in || in_s.clear_voltage_in;
   assign count_lvl[0] = !in_s.count_a_contact_in || in_s.count_a_voltage_in;
   assign count_lvl[1] = !in_s.count_b_contact_in || in_s.count_b_voltage_in;
   // Minimum accepted pulse width from the rate strap
   assign min_width = strap_s.rate_select_strap ? TIMER_W'(FAST_WIDTH) : TIMER_W'(SLOW_WIDTH);
   // Initial set mode counts towards zero, preset mode towards the preset
   assign target = strap_s.data_mode_strap ? preset_bcd : '0;
   assign match_now = (state.digit == target);

   // Step the digit chain by one, each digit passing its carry upward
   function automatic logic [NUM_DIGITS*DIGIT_W:0] step_digits(input logic [NUM_DIGITS-1:0][DIGIT_W-1:0] d,
                                                               input logic up);
      logic [NUM_DIGITS-1:0][DIGIT_W-1:0] r;
      logic carry_pulse_in;
      r = d;
      carry_pulse_in = 1'b1;
      for (int i = 0; i < NUM_DIGITS; i++) begin
         if (carry_pulse_in) begin
            if (up) begin
               carry_pulse_in = (d[i] == DIGIT_MAX);
               r[i] = carry_pulse_in ? DIGIT_RST : d[i] + 4'h1;
            end else begin
               carry_pulse_in = (d[i] == DIGIT_RST);
               r[i] = carry_pulse_in ? DIGIT_MAX : d[i] - 4'h1;
            end
         end
      end
      return {carry_pulse_in, r};
   endfunction

   // ==========================================
   // Next state
   always_comb begin
      logic [1:0] rise;
      logic do_count;
      logic up;
      logic [NUM_DIGITS*DIGIT_W:0] stepped;
      rise = '0;
      do_count = 1'b0;
      up = 1'b1;
      stepped = '0;
      next_state = state;
      // Two-flop synchroniser on every terminal
      next_state.sync1 = {inputs, straps};
      next_state.sync2 = state.sync1;
      // Width filter: a level is taken only after standing for the minimum width
      for (int i = 0; i < 2; i++) begin
         if (count_lvl[i] == state.filt[i]) begin
            next_state.filt_cnt[i] = '0;
         end else if (state.filt_cnt[i] + 1'b1 >= min_width) begin
            next_state.filt[i] = count_lvl[i];
            next_state.filt_cnt[i] = '0;
            rise[i] = count_lvl[i];
         end else begin
            next_state.filt_cnt[i] = state.filt_cnt[i] + 1'b1;
         end
      end
      // Counting mode decode
      case (in_mode)
         MBCD_UPDN_CMD: begin
            do_count = rise[0];
            up = !state.filt[1];
         end
         MBCD_UPDN_SEP: begin
            do_count = rise[0] ^ rise[1];
            up = rise[0];
         end
         MBCD_UPDN_PHASE: begin
            do_count = rise[0];
            up = !state.filt[1];
         end
         MBCD_UP_ONLY: begin
            do_count = rise[0];
            up = 1'b1;
         end
         default: begin
            do_count = 1'b0;
            up = 1'b1;
         end
      endcase
      stepped = step_digits(state.digit, up);
      next_state.pulse = do_count && !clear_now;
      next_state.carry = 1'b0;
      if (clear_now) begin
         // Clear loads the initial value in initial set mode, else zero
         next_state.digit = strap_s.data_mode_strap ? '0 : preset_bcd;
      end else if (do_count) begin
         next_state.digit = stepped[NUM_DIGITS*DIGIT_W-1:0];
         next_state.carry = stepped[NUM_DIGITS*DIGIT_W];
      end
      // Control output: held until clear, or a timed one-shot
      next_state.match_prev = match_now;
      if (clear_now) begin
         next_state.ctrl = 1'b0;
         next_state.shot_cnt = '0;
      end else if (match_now && !state.match_prev) begin
         next_state.ctrl = 1'b1;
         next_state.shot_cnt = TIMER_W'(ONE_SHOT - 1);
      end else if (state.ctrl && strap_s.output_mode_strap) begin
         if (state.shot_cnt == '0) begin
            next_state.ctrl = 1'b0;
         end else begin
            next_state.shot_cnt = state.shot_cnt - 1'b1;
         end
      end
      // Comparator unit: all used thumbwheel digit lines report coincidence
      next_state.cmp = &thumbwheel_coincidence_in[NUM_DIGITS-1:0];
   end

   // State register
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state <= STATE_RST;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================
   // Outputs, all straight from flip-flops
   generate
      for (genvar g = 0; g < NUM_DIGITS; g++) begin : g_digit
         assign bcd_out_weight1[g] = state.digit[g][0];
         assign bcd_out_weight2[g] = state.digit[g][1];
         assign bcd_out_weight4[g] = state.digit[g][2];
         assign bcd_out_weight8[g] = state.digit[g][3];
      end
   endgenerate
   assign count_pulse_out = state.pulse;
   assign carry_pulse_out = state.carry;
   assign control_out = state.ctrl;
   assign comparator_out = state.cmp;

   // ==========================================
   // Checks
   chk_digit_range: assert property (@(posedge clock) disable iff (!rst_b)
      state.digit[0] <= DIGIT_MAX && state.digit[NUM_DIGITS-1] <= DIGIT_MAX) else $error("digit above nine");
   chk_clear_zero: assert property (@(posedge clock) disable iff (!rst_b)
      clear_now && strap_s.data_mode_strap |=> state.digit == '0) else $error("clear did not zero count");
   chk_clear_load: assert property (@(posedge clock) disable iff (!rst_b)
      clear_now && !strap_s.data_mode_strap |=> state.digit == $past(preset_bcd)) else $error("initial value not loaded");
   chk_pulse_clear: assert property (@(posedge clock) disable iff (!rst_b)
      clear_now |=> !count_pulse_out) else $error("count pulse during clear");
   chk_pulse_step: assert property (@(posedge clock) disable iff (!rst_b)
      count_pulse_out |-> state.digit != $past(state.digit) || NUM_DIGITS == 0) else $error("pulse without step");
   chk_ctrl_match: assert property (@(posedge clock) disable iff (!rst_b)
      match_now && !state.match_prev && !clear_now |=> control_out) else $error("coincidence missed");
   chk_ctrl_hold: assert property (@(posedge clock) disable iff (!rst_b)
      control_out && !strap_s.output_mode_strap && !clear_now |=> control_out) else $error("held output dropped");
   chk_cmp_lines: assert property (@(posedge clock) disable iff (!rst_b)
      &thumbwheel_coincidence_in[NUM_DIGITS-1:0] |=> comparator_out) else $error("comparator missed");
   chk_filter_width: assert property (@(posedge clock) disable iff (!rst_b)
      state.filt[0] != $past(state.filt[0]) |-> $past(state.filt_cnt[0]) + 1'b1 >= $past(min_width))
      else $error("pulse shorter than minimum width taken");
   chk_rate_sel: assert property (@(posedge clock) disable iff (!rst_b)
      state.filt[0] != $past(state.filt[0]) && !$past(strap_s.rate_select_strap) |->
      $past(state.filt_cnt[0]) + 1'b1 >= TIMER_W'(SLOW_WIDTH)) else $error("slow rate level taken too soon");
endmodule

//--- mbcd_pkg.sv
// Shared constants and types for the modular decade counter control block
// ==========================================
// What this block does
// - Each digit shows count 0 to 9 on four weighted lines, level 1 means OFF; the code drives the digit bits uninverted, so 1 means the weight is set.
// - Clear applies on a shorted contact terminal or on the voltage terminal.
// - Two count inputs, each with contact and voltage terminals.
// - Output mode strap low selects held output, open selects one-shot output.
// - Rate strap low limits counting to 30 cps, open to 1,000 cps.
// - Input mode straps pick command, separate, phase or up-only counting.
// - A mode strap reads low when tied to common, high when open.
// - Data mode strap low selects initial set, open selects preset mode.
// - Control output asserts when every digit equals its preset digit in preset mode, or reaches zero in initial set mode.
// - A count pulse output drives the lowest-order digit.
// - Comparator output asserts when all thumbwheel digits report coincidence.
// - Separate up/down inputs have no phase restriction.
// - Each digit takes pulses from below and carries to the next digit.
package mbcd_pkg;
   // ==========================================
   // Timing
   localparam int unsigned CLOCK_MHZ = 25;
   localparam int unsigned SLOW_WIDTH_US = 16700;
   localparam int unsigned FAST_WIDTH_US = 500;
   localparam int unsigned ONE_SHOT_US = 500000;
   localparam int unsigned SLOW_WIDTH_CYC = SLOW_WIDTH_US * CLOCK_MHZ;
   localparam int unsigned FAST_WIDTH_CYC = FAST_WIDTH_US * CLOCK_MHZ;
   localparam int unsigned ONE_SHOT_CYC = ONE_SHOT_US * CLOCK_MHZ;
   localparam int unsigned TIMER_W = 24;
   // ==========================================
   // Digit layout and reset values
   localparam int unsigned DIGIT_W = 4;
   localparam logic [3:0] DIGIT_MAX = 4'h9;
   localparam logic [3:0] DIGIT_RST = 4'h0;
   localparam int unsigned THUMB_LINES = 8;
   // ==========================================
   // Input counting modes, coded as {first strap, second strap}
   typedef enum logic [1:0] {
      MBCD_UP_ONLY = 2'b00,
      MBCD_UPDN_PHASE = 2'b01,
      MBCD_UPDN_SEP = 2'b10,
      MBCD_UPDN_CMD = 2'b11
   } mbcd_in_mode_t;
   // Strap bundle, each bit low when tied to common
   typedef struct packed {
      logic output_mode_strap;
      logic rate_select_strap;
      logic input_mode_strap_first;
      logic input_mode_strap_second;
      logic data_mode_strap;
   } mbcd_straps_t;
   // Raw input terminals
   typedef struct packed {
      logic clear_contact_in;
      logic clear_voltage_in;
      logic count_a_contact_in;
      logic count_b_contact_in;
      logic count_a_voltage_in;
      logic count_b_voltage_in;
   } mbcd_inputs_t;
   // Idle terminal levels: contacts open, voltage terminals low, straps open
   localparam mbcd_inputs_t INPUTS_IDLE = 6'b101100;
   localparam mbcd_straps_t STRAPS_IDLE = 5'b11111;
endpackage

//--- mbcd_src.sv
// Model of the contacts and sensors wired to the clear and count terminals
`timescale 1ns/100ps
module mbcd_src (
   // Clock
   input wire logic clock,
   // Terminals of the control unit
   output mbcd_pkg::mbcd_inputs_t inputs
);
   import mbcd_pkg::*;
   localparam int CI[3] = '{5, 3, 2};
   localparam int VI[3] = '{4, 1, 0};
   integer seed = 32'h3da6;
   // Contacts open and voltage terminals low while idle
   initial inputs = INPUTS_IDLE;
   // Channel 0 clear, 1 count a, 2 count b; the terminal kind is picked at random
   task automatic level(input int ch, input bit on);
      bit v;
      v = 1'($random(seed));
      @(posedge clock);
      inputs[CI[ch]] <= !(on && !v);
      inputs[VI[ch]] <= on && v;
   endtask
   // One pulse, held active w+1 cycles and idle w+1 cycles
   task automatic pulse(input int ch, input int w);
      level(ch, 1'b1);
      repeat (w) @(posedge clock);
      level(ch, 1'b0);
      repeat (w) @(posedge clock);
   endtask
endmodule

//--- modular_bcd_count_control_test.sv
// Self-checking bench of the decade counter control unit
`timescale 1ns/100ps
module modular_bcd_count_control_test;
   import mbcd_pkg::*;
   localparam int ND = 2;
   localparam int FW = 3;
   localparam int SW = 8;
   localparam int OS = 40;
   logic clock;
   logic rst_b = 1'b0;
   mbcd_inputs_t inputs;
   mbcd_straps_t straps = 5'b01001;
   logic [7:0] preset_bcd = 8'h00;
   logic [7:0] thumb = 8'h00;
   logic [ND-1:0] w1, w2, w4, w8;
   logic cpo, cao, ctl, cmp;
   int fails = 0;
   int check_count = 0;
   int val = 0;
   int np = 0;
   int nc = 0;
   int np_exp = 0;
   int pw = FW + 3;
   mbcd_ctrl #(.NUM_DIGITS(ND), .SLOW_WIDTH(SW), .FAST_WIDTH(FW), .ONE_SHOT(OS)) i_dut (
      .clock(clock), .rst_b(rst_b), .inputs(inputs), .straps(straps), .preset_bcd(preset_bcd),
      .thumbwheel_coincidence_in(thumb), .bcd_out_weight1(w1), .bcd_out_weight2(w2),
      .bcd_out_weight4(w4), .bcd_out_weight8(w8), .count_pulse_out(cpo), .carry_pulse_out(cao),
      .control_out(ctl), .comparator_out(cmp));
   mbcd_src i_src (.clock(clock), .inputs(inputs));
   // Clock of 40 ns
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // Count the one-cycle pulses
   always @(posedge clock) begin
      np <= np + (rst_b && cpo === 1'b1);
      nc <= nc + (rst_b && cao === 1'b1);
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
         fails++;
      end
   endtask
   // Compare every digit and the pulse count with the model
   task automatic digits();
      for (int i = 0; i < ND; i++) begin
         chk("digit", {w8[i], w4[i], w2[i], w1[i]}, (val / 10 ** i) % 10);
      end
      chk("count pulses", np, np_exp);
   endtask
   task automatic step(input int ch, input int d);
      i_src.pulse(ch, pw);
      val = (val + d + 100) % 100;
      np_exp += (d != 0);
      digits();
   endtask
   task automatic set_straps(input logic [4:0] s);
      @(posedge clock);
      straps <= s;
      repeat (4) @(posedge clock);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clock);
      chk("control", ctl, 1'b0);
      digits();
      rst_b <= 1'b1;
      // Up only, across the digit carry; count b is ignored
      repeat (12) step(1, 1);
      step(2, 0);
      $display("up only done");
      // Down and up in the three up/down modes
      for (int m = 1; m < 4; m++) begin
         set_straps({2'b01, m[1:0], 1'b1});
         if (m == 2) begin
            step(2, -1);
         end else begin
            i_src.level(2, 1'b1);
            repeat (pw) @(posedge clock);
            step(1, -1);
            i_src.level(2, 1'b0);
            repeat (pw) @(posedge clock);
         end
         step(1, 1);
      end
      $display("up/down modes done");
      // A 5-cycle pulse is too short at the slow rate only; a glitch never counts
      pw = 4;
      set_straps(5'b00001);
      step(1, 0);
      // A pulse of the full slow width is taken
      pw = SW;
      step(1, 1);
      set_straps(5'b01001);
      pw = 4;
      step(1, 1);
      pw = 0;
      step(1, 0);
      pw = FW + 3;
      $display("rate done");
      // Held coincidence output, dropped by clear
      preset_bcd <= 8'h16;
      step(1, 1);
      chk("control", ctl, 1'b0);
      step(1, 1);
      chk("control", ctl, 1'b1);
      step(1, 1);
      chk("control", ctl, 1'b1);
      i_src.pulse(0, pw);
      val = 0;
      digits();
      chk("control", ctl, 1'b0);
      // One-shot coincidence output
      preset_bcd <= 8'h01;
      set_straps(5'b11001);
      step(1, 1);
      chk("control", ctl, 1'b1);
      repeat (OS + 4) @(posedge clock);
      chk("control", ctl, 1'b0);
      $display("control done");
      // Initial set loads the preset; reaching zero raises the output
      set_straps(5'b01000);
      preset_bcd <= 8'h98;
      i_src.pulse(0, pw);
      val = 98;
      digits();
      step(1, 1);
      step(1, 1);
      chk("carry pulses", nc, 1);
      chk("control", ctl, 1'b1);
      $display("initial set done");
      // Comparator follows the used thumbwheel lines
      for (int k = 0; k < 6; k++) begin
         @(posedge clock);
         thumb <= (k == 0) ? 8'h03 : (k == 1) ? 8'hfd : 8'($random(i_src.seed));
         repeat (4) @(posedge clock);
         chk("comparator", cmp, &thumb[ND-1:0]);
      end
      $display("comparator done");
      final_report();
   end
   // Watchdog; the tests need about 560 cycles
   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      final_report();
   end
endmodule
